// ### src/dag_pkg.sv
/*
 Constants for the data address generator: mode codes, access sizes, page
 bases and field positions. Assumes a 16-bit offset space per data segment.
*/
`default_nettype none
package dag_pkg;
    // Addressing modes
    typedef enum logic [3:0] {
        MODE_SFR      = 4'h0,
        MODE_FIXED    = 4'h1,
        MODE_CURPAGE  = 4'h2,
        MODE_DIRECT   = 4'h3,
        MODE_IND      = 4'h4,
        MODE_POSTINC  = 4'h5,
        MODE_POSTDEC  = 4'h6,
        MODE_DISP7    = 4'h7,
        MODE_BASE16   = 4'h8,
        MODE_REGDISP  = 4'h9,
        MODE_SBAFIX   = 4'ha
    } dag_mode_type;
    // Access sizes
    typedef enum logic [1:0] {
        SIZE_BYTE = 2'h0,
        SIZE_WORD = 2'h1,
        SIZE_BIT  = 2'h2
    } dag_size_type;
    // Instruction classes relevant to bit-area use
    typedef enum logic [2:0] {
        OP_OTHER      = 3'h0,
        OP_SET_BIT    = 3'h1,
        OP_CLEAR_BIT  = 3'h2,
        OP_JUMP_SET   = 3'h3,
        OP_JUMP_CLEAR = 3'h4
    } dag_op_type;
    localparam logic [15:0] SFR_PAGE_BASE   = 16'h0000;
    localparam logic [15:0] FIXED_PAGE_BASE = 16'h0200;
    localparam logic [15:0] SBA_FIX_BASE    = 16'h02c0;
    localparam logic [15:0] WORD_STEP       = 16'h0002;
    localparam logic [15:0] BYTE_STEP       = 16'h0001;
    localparam int          DISP_MSB        = 6;
    localparam int          SEG_BITS        = 4;
    localparam int          SET_BITS        = 3;
    localparam int          SBA_BITS        = 9;
    localparam int          SBA_BYTE_LSB    = 3;
    localparam int          OFFSET_MSB      = 7;
    localparam logic [3:0]  SEG_RESET       = 4'h0;
endpackage
`default_nettype wire

// ### src/dag_top.sv
/*
 Data address generator: one-cycle registered effective address for every
 data-space mode, plus pointer write-back for post-increment/decrement.
 Assumes decode supplies operand fields with a request strobe, and the
 register file supplies the pointer registers of all eight sets flattened.
 Operand and pointer inputs must be steady at the edge that takes a request;
 the pointer write-back is only offered, the register file decides to apply it.
 Current-page bit area and code-space addressing are handled elsewhere.
*/
// How it works
// - SFR page: one-byte offset into page 0-0FFH, any access size.
// - Word access at an odd address uses the even address below.
// - Specific SFRs may exempt themselves from word alignment via an input.
// - FIXED page: one-byte offset into 200H-2FFH.
// - Current page: page_base_high byte selects page, offset is low byte.
// - Direct: two-byte operand is the whole 16-bit address.
// - Simple indirect uses data_pointer or index_reg_one unchanged.
// - Post-increment accesses then adds 2 for word, 1 otherwise.
// - Post-decrement accesses then subtracts 2 for word, 1 otherwise.
// - Sign-extended 7-bit displacement added to data_pointer or user_stack_pointer.
// - base_immediate_word plus index one or two, carry discarded.
// - index_reg_one plus zero-extended accum_low_byte or local_reg_zero.
// - Fixed single_bit_area covers 2C0H.0-2FFH.7, bit accesses only.
// - Bit area allowed only for set, clear, jump-if-set, jump-if-clear.
// - Pointer set chosen by three-bit reg_set_select of status_word_low.
// - Segment is low four bits of data segment register, upper read zero.
`timescale 1ns/1ps
`default_nettype none
module dag_top (
    // Clock and reset
    input  wire logic                 CORE_CLK,
    input  wire logic                 RESETN,
    // Request from instruction decode
    input  wire logic                 REQ_VALID,
    input  wire dag_pkg::dag_mode_type MODE,
    input  wire dag_pkg::dag_size_type SIZE,
    input  wire dag_pkg::dag_op_type  OP_CLASS,
    input  wire logic [15:0]          OPERAND,
    input  wire logic                 SEL_ALT,
    input  wire logic                 SFR_NO_ALIGN,
    // Register file values
    input  wire logic [7:0]           STATUS_WORD_LOW,
    input  wire logic [7:0]           PAGE_BASE_HIGH,
    input  wire logic [7:0]           ACCUM_LOW_BYTE,
    input  wire logic [7:0]           LOCAL_REG_ZERO,
    input  wire logic [127:0]         DATA_POINTER_ALL,
    input  wire logic [127:0]         INDEX_REG_ONE_ALL,
    input  wire logic [127:0]         INDEX_REG_TWO_ALL,
    input  wire logic [127:0]         USER_STACK_POINTER_ALL,
    // Data segment register write
    input  wire logic                 SEG_WR,
    input  wire logic [7:0]           SEG_WDATA,
    output logic [7:0]                SEG_RDATA,
    // Address result
    output logic                      ADDR_VALID,
    output logic [19:0]               PHYS_ADDR,
    output logic [15:0]               EFF_ADDR,
    output logic [2:0]                BIT_POS,
    output logic                      ADDR_ERR,
    // Pointer write-back
    output logic                      DP_WB_VALID,
    output logic [2:0]                DP_WB_SET,
    output logic [15:0]               DP_WB_DATA
);
    typedef struct packed {
        // Data segment number
        logic [dag_pkg::SEG_BITS-1:0] seg;
        // Address result
        logic        valid;
        logic [19:0] phys;
        logic [15:0] eff;
        logic [2:0]  bitpos;
        logic        err;
        // Pointer write-back
        logic        wb_valid;
        logic [2:0]  wb_set;
        logic [15:0] wb_data;
    } dag_state_type;

    dag_state_type s_q;
    dag_state_type s_d;

    // Pick one 16-bit pointer from the eight flattened sets
    function automatic logic [15:0] pick(input logic [127:0] all, input logic [2:0] set);
        pick = all[{set, 4'h0} +: 16];
    endfunction

    // Pointer after the access; wraps at 16 bits like every other sum here
    function automatic logic [15:0] step_ptr(input logic [15:0] ptr, input logic [15:0] amount,
                                             input logic down);
        step_ptr = down ? (ptr - amount) : (ptr + amount);
    endfunction

    // Selected pointer set and its registers
    logic [2:0]  set_sel;
    logic [15:0] dp;
    logic [15:0] x1;
    logic [15:0] x2;
    logic [15:0] user_stack_pointer;

    // Widened operand fields and per-request helpers
    logic [15:0] disp_ext;
    logic [15:0] byte_disp;
    logic [15:0] sba_byte;
    logic [15:0] raw;
    logic [15:0] step;
    logic        align_on;
    logic        bad;

    assign set_sel = STATUS_WORD_LOW[dag_pkg::SET_BITS-1:0];
    assign dp      = pick(DATA_POINTER_ALL, set_sel);
    assign x1      = pick(INDEX_REG_ONE_ALL, set_sel);
    assign x2      = pick(INDEX_REG_TWO_ALL, set_sel);
    assign user_stack_pointer     = pick(USER_STACK_POINTER_ALL, set_sel);
    assign step    = (SIZE == dag_pkg::SIZE_WORD) ? dag_pkg::WORD_STEP : dag_pkg::BYTE_STEP;

    // sign from operand bit 6, reach -64 to +63
    assign disp_ext  = {{9{OPERAND[dag_pkg::DISP_MSB]}}, OPERAND[dag_pkg::DISP_MSB:0]};
    // zero-extended, so a byte above 7FH never reaches backwards
    assign byte_disp = {8'h00, (SEL_ALT ? LOCAL_REG_ZERO : ACCUM_LOW_BYTE)};
    // byte index of the bit above the area base
    assign sba_byte  = {10'h000, OPERAND[dag_pkg::SBA_BITS-1:dag_pkg::SBA_BYTE_LSB]};
    // exempt SFRs keep the odd address; no other mode may skip
    assign align_on  = (SIZE == dag_pkg::SIZE_WORD) && !(MODE == dag_pkg::MODE_SFR && SFR_NO_ALIGN);

    // Raw address per mode; all sums wrap at 16 bits
    always_comb begin
        bad = 1'b0;
        raw = 16'h0000;
        case (MODE)
            dag_pkg::MODE_SFR:     raw = dag_pkg::SFR_PAGE_BASE | {8'h00, OPERAND[dag_pkg::OFFSET_MSB:0]};
            dag_pkg::MODE_FIXED:   raw = dag_pkg::FIXED_PAGE_BASE | {8'h00, OPERAND[dag_pkg::OFFSET_MSB:0]};
            dag_pkg::MODE_CURPAGE: raw = {PAGE_BASE_HIGH, OPERAND[dag_pkg::OFFSET_MSB:0]};
            dag_pkg::MODE_DIRECT:  raw = OPERAND;
            dag_pkg::MODE_IND:     raw = SEL_ALT ? x1 : dp;
            dag_pkg::MODE_POSTINC,
            dag_pkg::MODE_POSTDEC: raw = dp;
            dag_pkg::MODE_DISP7:   raw = (SEL_ALT ? user_stack_pointer : dp) + disp_ext;
            dag_pkg::MODE_BASE16:  raw = OPERAND + (SEL_ALT ? x2 : x1);
            dag_pkg::MODE_REGDISP: raw = x1 + byte_disp;
            dag_pkg::MODE_SBAFIX: begin
                // 512 bits from 2C0H, byte index in upper operand bits
                raw = dag_pkg::SBA_FIX_BASE + sba_byte;
                // restricted to the four bit instructions
                bad = (SIZE != dag_pkg::SIZE_BIT) || (OP_CLASS == dag_pkg::OP_OTHER);
            end
            // Unknown code: flagged, address left at zero
            default:               bad = 1'b1;
        endcase
    end

    // Next state
    always_comb begin
        s_d          = s_q;
        s_d.valid    = REQ_VALID;
        s_d.wb_valid = 1'b0;
        if (SEG_WR) begin
            s_d.seg = SEG_WDATA[dag_pkg::SEG_BITS-1:0];
        end
        // Data fields move only on a taken request
        if (REQ_VALID) begin
            s_d.err    = bad;
            s_d.eff    = raw;
            s_d.bitpos = (MODE == dag_pkg::MODE_SBAFIX) ? OPERAND[dag_pkg::SBA_BYTE_LSB-1:0] : 3'h0;
            if (align_on) begin
                s_d.eff = {raw[15:1], 1'b0};
            end
            s_d.phys = {s_q.seg, s_d.eff};
            // Write-back names the set used for this access
            s_d.wb_set = set_sel;
            if (MODE == dag_pkg::MODE_POSTINC) begin
                s_d.wb_valid = 1'b1;
                s_d.wb_data  = step_ptr(dp, step, 1'b0);
            end
            if (MODE == dag_pkg::MODE_POSTDEC) begin
                s_d.wb_valid = 1'b1;
                s_d.wb_data  = step_ptr(dp, step, 1'b1);
            end
        end
    end

    // State register
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            s_q     <= '0;
            // Segment reset value is named, not assumed zero
            s_q.seg <= dag_pkg::SEG_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flops; upper segment bits read zero
    assign SEG_RDATA   = {4'h0, s_q.seg};

    // Address, bit and error fields hold until the next taken request; ADDR_VALID follows REQ_VALID each cycle
    assign ADDR_VALID  = s_q.valid;
    assign PHYS_ADDR   = s_q.phys;
    assign EFF_ADDR    = s_q.eff;
    assign BIT_POS     = s_q.bitpos;
    assign ADDR_ERR    = s_q.err;

    // Write-back is a one-cycle offer to the register file
    assign DP_WB_VALID = s_q.wb_valid;
    assign DP_WB_SET   = s_q.wb_set;
    assign DP_WB_DATA  = s_q.wb_data;
endmodule
`default_nettype wire

// ### bench/dag_props.sv
/*
 Property checker for the data address generator.
 Assumes it is bound to dag_top and sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none
module dag_props (
    // Clock and reset
    input wire logic                  CORE_CLK,
    input wire logic                  RESETN,
    // Request
    input wire logic                  REQ_VALID,
    input wire dag_pkg::dag_mode_type MODE,
    input wire dag_pkg::dag_size_type SIZE,
    input wire dag_pkg::dag_op_type   OP_CLASS,
    input wire logic [15:0]           OPERAND,
    input wire logic                  SFR_NO_ALIGN,
    input wire logic [7:0]            STATUS_WORD_LOW,
    // Segment register
    input wire logic                  SEG_WR,
    input wire logic [7:0]            SEG_WDATA,
    input wire logic [7:0]            SEG_RDATA,
    // Results
    input wire logic                  ADDR_VALID,
    input wire logic                  ADDR_ERR,
    input wire logic                  DP_WB_VALID,
    input wire logic [19:0]           PHYS_ADDR,
    input wire logic [15:0]           EFF_ADDR,
    input wire logic [2:0]            DP_WB_SET
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);
    // Pointer-stepping request
    sequence s_step;
        REQ_VALID && (MODE == dag_pkg::MODE_POSTINC || MODE == dag_pkg::MODE_POSTDEC);
    endsequence
    property p_lat; REQ_VALID |=> ADDR_VALID; endproperty
    property p_idle; !REQ_VALID |=> !ADDR_VALID && !DP_WB_VALID; endproperty
    property p_join; ADDR_VALID |-> PHYS_ADDR[15:0] == EFF_ADDR; endproperty
    // Skipped the cycle after a segment write: a request taken with that write keeps the old segment
    property p_seg; ADDR_VALID && !$past(SEG_WR) |-> PHYS_ADDR[19:16] == SEG_RDATA[3:0]; endproperty
    property p_segrd; SEG_WR |=> SEG_RDATA == {4'h0, $past(SEG_WDATA[3:0])}; endproperty
    property p_align; REQ_VALID && SIZE == dag_pkg::SIZE_WORD && MODE != dag_pkg::MODE_SFR |=> !EFF_ADDR[0];
    endproperty
    property p_sfr; REQ_VALID && MODE == dag_pkg::MODE_SFR && SIZE == dag_pkg::SIZE_BYTE
        |=> EFF_ADDR == {8'h00, $past(OPERAND[7:0])}; endproperty
    property p_fix; REQ_VALID && MODE == dag_pkg::MODE_FIXED && SIZE == dag_pkg::SIZE_BYTE
        |=> EFF_ADDR == {8'h02, $past(OPERAND[7:0])}; endproperty
    property p_dir; REQ_VALID && MODE == dag_pkg::MODE_DIRECT && SIZE == dag_pkg::SIZE_BYTE
        |=> EFF_ADDR == $past(OPERAND); endproperty
    property p_wb; s_step |=> DP_WB_VALID && DP_WB_SET == $past(STATUS_WORD_LOW[2:0]); endproperty
    property p_sba; REQ_VALID && MODE == dag_pkg::MODE_SBAFIX
        && (SIZE != dag_pkg::SIZE_BIT || OP_CLASS == dag_pkg::OP_OTHER) |=> ADDR_ERR; endproperty
    a_lat: assert property (p_lat) else $error("address late");
    a_idle: assert property (p_idle) else $error("spurious valid");
    a_join: assert property (p_join) else $error("offset mismatch");
    a_seg: assert property (p_seg) else $error("segment mismatch");
    a_segrd: assert property (p_segrd) else $error("segment readback");
    a_align: assert property (p_align) else $error("odd word address");
    a_sfr: assert property (p_sfr) else $error("sfr page address");
    a_fix: assert property (p_fix) else $error("fixed page address");
    a_dir: assert property (p_dir) else $error("direct address");
    a_wb: assert property (p_wb) else $error("write-back set");
    a_sba: assert property (p_sba) else $error("bit area misuse not flagged");
endmodule
bind dag_top dag_props u_props (
    .CORE_CLK        (CORE_CLK),
    .RESETN          (RESETN),
    .REQ_VALID       (REQ_VALID),
    .MODE            (MODE),
    .SIZE            (SIZE),
    .OP_CLASS        (OP_CLASS),
    .OPERAND         (OPERAND),
    .SFR_NO_ALIGN    (SFR_NO_ALIGN),
    .STATUS_WORD_LOW (STATUS_WORD_LOW),
    .SEG_WR          (SEG_WR),
    .SEG_WDATA       (SEG_WDATA),
    .SEG_RDATA       (SEG_RDATA),
    .ADDR_VALID      (ADDR_VALID),
    .ADDR_ERR        (ADDR_ERR),
    .DP_WB_VALID     (DP_WB_VALID),
    .PHYS_ADDR       (PHYS_ADDR),
    .EFF_ADDR        (EFF_ADDR),
    .DP_WB_SET       (DP_WB_SET)
);
`default_nettype wire

// ### bench/dag_mem_model.sv
/*
 Data memory stand-in: logs each presented physical address.
 Assumes the valid strobe pulses once per access.
*/
`timescale 1ns/1ps
`default_nettype none
module dag_mem_model (
    // Access side
    input  wire logic        clk,
    input  wire logic        valid,
    input  wire logic [19:0] addr,
    // Log of the last access
    output logic [19:0]      last_addr
);
    // Latch only on a real access
    always_ff @(posedge clk) if (valid) last_addr <= addr;
endmodule
`default_nettype wire

// ### bench/dag_bench.sv
/*
 Directed bench for the data address generator, one task per scenario.
 Assumes dag_pkg, dag_top, the checker and the memory model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module dag_bench;
    logic clk = 1'h0, rst_n = 1'h0, rv = 1'h0, alt = 1'h0, na = 1'h0, sw = 1'h0, av, err, wbv;
    logic [3:0] md = 4'h0;
    logic [2:0] op = 3'h0, bp, wbs;
    logic [1:0] sz = 2'h0;
    logic [15:0] opd = 16'h0000, ea, wbd;
    logic [7:0] swl = 8'h05, pbh = 8'h5a, al = 8'hff, r0 = 8'h10, swd = 8'h00, srd;
    // Only set 5 is meaningful, others trap a wrong set select
    logic [127:0] dp = {{2{16'h7777}}, 16'h1001, {5{16'h7777}}}, x1 = {{2{16'h7777}}, 16'hff80, {5{16'h7777}}};
    logic [127:0] x2 = {{2{16'h7777}}, 16'hfff0, {5{16'h7777}}}, user_stack_pointer = {{2{16'h7777}}, 16'h4000, {5{16'h7777}}};
    logic [19:0] pa, la;
    int err_count = 0, num_checks = 0, cyc = 0;
    dag_top u_dut (.CORE_CLK(clk), .RESETN(rst_n), .REQ_VALID(rv), .MODE(dag_pkg::dag_mode_type'(md)),
        .SIZE(dag_pkg::dag_size_type'(sz)), .OP_CLASS(dag_pkg::dag_op_type'(op)), .OPERAND(opd), .SEL_ALT(alt),
        .SFR_NO_ALIGN(na), .STATUS_WORD_LOW(swl), .PAGE_BASE_HIGH(pbh), .ACCUM_LOW_BYTE(al), .LOCAL_REG_ZERO(r0),
        .DATA_POINTER_ALL(dp), .INDEX_REG_ONE_ALL(x1), .INDEX_REG_TWO_ALL(x2), .USER_STACK_POINTER_ALL(user_stack_pointer),
        .SEG_WR(sw), .SEG_WDATA(swd), .SEG_RDATA(srd), .ADDR_VALID(av), .PHYS_ADDR(pa), .EFF_ADDR(ea),
        .BIT_POS(bp), .ADDR_ERR(err), .DP_WB_VALID(wbv), .DP_WB_SET(wbs), .DP_WB_DATA(wbd));
    dag_mem_model u_mem (.clk(clk), .valid(av), .addr(pa), .last_addr(la));
    always #10 clk = ~clk;
    // Hang guard, far above the few dozen cycles needed
    always @(posedge clk) begin
        cyc++;
        if (cyc == 500) begin
            err_count++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [19:0] g, input logic [19:0] e);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Request held across back-to-back calls; judged one cycle later
    task automatic rq(input logic [3:0] m, input logic [1:0] s, input logic [15:0] o, input logic a,
                      input logic [15:0] e);
        md = m;
        sz = s;
        opd = o;
        alt = a;
        rv = 1'h1;
        @(negedge clk);
        chk({av, 3'h0, ea}, {4'h8, e});
    endtask
    task automatic idle();
        rv = 1'h0;
        @(negedge clk);
    endtask
    task automatic t_pages();
        rq(4'h0, 2'h0, 16'h0037, 1'h0, 16'h0037);
        rq(4'h0, 2'h1, 16'h0037, 1'h0, 16'h0036);
        na = 1'h1;
        rq(4'h0, 2'h1, 16'h0037, 1'h0, 16'h0037);
        rq(4'h1, 2'h1, 16'h00a5, 1'h0, 16'h02a4);
        na = 1'h0;
        rq(4'h1, 2'h0, 16'h00a5, 1'h0, 16'h02a5);
        rq(4'h2, 2'h0, 16'h0033, 1'h0, 16'h5a33);
        rq(4'h3, 2'h1, 16'habcd, 1'h0, 16'habcc);
    endtask
    task automatic t_ptr();
        rq(4'h4, 2'h0, 16'h0000, 1'h0, 16'h1001);
        chk({wbv, wbs, 16'h0000}, 20'h50000);
        rq(4'h4, 2'h0, 16'h0000, 1'h1, 16'hff80);
        rq(4'h5, 2'h1, 16'h0000, 1'h0, 16'h1000);
        chk({wbv, wbs, wbd}, 20'hd1003);
        rq(4'h6, 2'h2, 16'h0000, 1'h0, 16'h1001);
        chk({wbv, wbs, wbd}, 20'hd1000);
        rq(4'h7, 2'h0, 16'h0040, 1'h0, 16'h0fc1);
        rq(4'h7, 2'h0, 16'h003f, 1'h1, 16'h403f);
        rq(4'h8, 2'h0, 16'h0100, 1'h0, 16'h0080);
        rq(4'h8, 2'h0, 16'h0020, 1'h1, 16'h0010);
        rq(4'h9, 2'h0, 16'h0000, 1'h0, 16'h007f);
        rq(4'h9, 2'h0, 16'h0000, 1'h1, 16'hff90);
    endtask
    task automatic t_sba();
        for (int i = 1; i < 5; i++) begin
            op = i[2:0];
            rq(4'ha, 2'h2, 16'h01fb, 1'h0, 16'h02ff);
            chk({err, bp}, 20'h3);
        end
        rq(4'ha, 2'h0, 16'h01fb, 1'h0, 16'h02ff);
        chk({err, bp}, 20'hb);
        op = 3'h0;
        rq(4'ha, 2'h2, 16'h0000, 1'h0, 16'h02c0);
        chk({err, bp}, 20'h8);
        rq(4'hb, 2'h0, 16'h1234, 1'h0, 16'h0000);
        chk({err, bp}, 20'h8);
    endtask
    task automatic t_seg();
        sw = 1'h1;
        swd = 8'hfc;
        rq(4'h3, 2'h0, 16'h1234, 1'h0, 16'h1234);
        sw = 1'h0;
        chk({pa[19:16], 8'h00, srd}, 20'h0000c);
        rq(4'h3, 2'h0, 16'h1234, 1'h0, 16'h1234);
        idle();
        chk(la, 20'hc1234);
    endtask
    // Mid-run reset clears all, segment back to zero, request at once
    task automatic t_reset();
        rst_n = 1'h0;
        @(negedge clk);
        chk({av, err, wbv, 1'h0, ea}, 20'h00000);
        chk(pa, 20'h00000);
        chk({bp, wbs, 6'h00, srd}, 20'h00000);
        chk({4'h0, wbd}, 20'h00000);
        rst_n = 1'h1;
        rq(4'h3, 2'h0, 16'h1234, 1'h0, 16'h1234);
        chk(pa, 20'h01234);
    endtask
    initial begin
        repeat (6) @(negedge clk);
        rst_n = 1'h1;
        @(negedge clk);
        t_pages();
        t_ptr();
        idle();
        t_sba();
        t_seg();
        t_reset();
        print_verdict();
    end
endmodule
`default_nettype wire
